/* File: verilog/vslc_pkg.sv */
package vslc_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SLICER_CONTROL_ONE = 8'h40;
    localparam logic [7:0] IDX_LINE_CTRL_FIRST    = 8'h41;
    localparam logic [7:0] IDX_LINE_CTRL_LAST     = 8'h57;
    localparam logic [7:0] IDX_SYNC_PATTERN       = 8'h58;
    localparam logic [7:0] IDX_HORIZ_LOW          = 8'h59;
    localparam logic [7:0] IDX_VERT_LOW           = 8'h5a;
    localparam logic [7:0] IDX_FIELD_MSBS         = 8'h5b;
    localparam logic [7:0] IDX_SLICER_STATUS      = 8'h5c;
    localparam int         NUM_LINE_CTRL          = 23;
    localparam int         FIRST_CTRL_LINE        = 2;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_PARITY_DIS   = 6;
    localparam int BIT_SYNC_STRICT  = 5;
    localparam int BIT_LEVEL_DIS    = 4;
    localparam int BIT_FIELD_INV    = 7;
    localparam int BIT_RECODE       = 6;
    localparam int BIT_VERT_MSB     = 4;
    localparam int HORIZ_MSB_HI     = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LINE_CTRL    = 8'hff;
    localparam logic [7:0] RST_SYNC_PATTERN = 8'h40;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [9:0] VERT_OFFSET_MAX  = 10'h138;
    // ------------------------------------------------------------
    // line payload kinds and their sync codes
    // ------------------------------------------------------------
    localparam logic [3:0] KIND_WIDESCREEN  = 4'h3;
    localparam logic [3:0] KIND_CAPTION21   = 4'h5;
    localparam logic [3:0] KIND_BLANK_VIDEO = 4'h6;
    localparam logic [3:0] KIND_TC625       = 4'h9;
    localparam logic [3:0] KIND_TC525       = 4'ha;
    localparam logic [3:0] KIND_JAPAN_FSW   = 4'he;
    localparam logic [3:0] KIND_ACTIVE      = 4'hf;
    localparam logic [23:0] SYNC_CAPTION    = 24'h000001;
    localparam logic [23:0] SYNC_WIDESCREEN = 24'h1e3c1f;
    localparam logic [23:0] MASK_CAPTION    = 24'h000007;
    localparam logic [23:0] MASK_PROG       = 24'h0000ff;
    localparam logic [23:0] MASK_WIDE       = 24'hffffff;
    localparam logic [4:0]  LEN_CAPTION     = 5'd3;
    localparam logic [4:0]  LEN_PROG        = 5'd8;
    localparam logic [4:0]  LEN_WIDE        = 5'd24;
    localparam logic [7:0]  BYTE_ALL_LOW    = 8'h00;
    localparam logic [7:0]  BYTE_ALL_HIGH   = 8'hff;
    localparam logic [7:0]  BYTE_LOW_SUB    = 8'h03;
    localparam logic [7:0]  BYTE_HIGH_SUB   = 8'hfc;
    localparam logic [1:0]  CHECKED_BYTES   = 2'd2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SYNC = 4'b0010,
        ST_DATA = 4'b0100,
        ST_RAW  = 4'b1000
    } vslc_state_t;
endpackage

/* File: verilog/vslc_slicer.sv */
`timescale 1ns/10ps
`default_nettype none
module vslc_slicer (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  vid_sample,
    input  wire logic        vid_valid,
    input  wire logic        line_start,
    input  wire logic        field_start,
    input  wire logic        field_in,
    output logic [7:0]       out_data,
    output logic             out_valid,
    output logic [3:0]       out_kind,
    output logic             out_field,
    output logic             out_parity_err
);
    // one clock domain; every property below is clocked and reset here
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] slicer_control_one;
    logic [7:0] line_type_select [vslc_pkg::NUM_LINE_CTRL];
    logic [7:0] programmable_sync_pattern;
    logic [7:0] horiz_window_low;
    logic [7:0] vert_window_low;
    logic [7:0] field_and_offset_msbs;
    logic [7:0] idx;
    logic       wr_en;
    logic       hit;
    logic [7:0] rd_byte;
    logic [7:0] slice_lvl;
    logic [4:0] lcr_wsel;

    assign idx      = paddr[9:2];
    assign wr_en    = psel & penable & pwrite & hit;
    assign lcr_wsel = 5'(idx - vslc_pkg::IDX_LINE_CTRL_FIRST);
    // zero-wait slave: read data is latched in setup, so pready can stay high
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit;

    // address decode and read mux, status word at the end of the map
    always_comb begin
        hit     = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 &&
                  idx >= vslc_pkg::IDX_SLICER_CONTROL_ONE &&
                  idx <= vslc_pkg::IDX_SLICER_STATUS;
        rd_byte = vslc_pkg::RST_ZERO;
        if (idx == vslc_pkg::IDX_SLICER_CONTROL_ONE) begin
            rd_byte = slicer_control_one;
        end else if (idx >= vslc_pkg::IDX_LINE_CTRL_FIRST && idx <= vslc_pkg::IDX_LINE_CTRL_LAST) begin
            rd_byte = line_type_select[lcr_wsel];
        end else if (idx == vslc_pkg::IDX_SYNC_PATTERN) begin
            rd_byte = programmable_sync_pattern;
        end else if (idx == vslc_pkg::IDX_HORIZ_LOW) begin
            rd_byte = horiz_window_low;
        end else if (idx == vslc_pkg::IDX_VERT_LOW) begin
            rd_byte = vert_window_low;
        end else if (idx == vslc_pkg::IDX_FIELD_MSBS) begin
            rd_byte = field_and_offset_msbs;
        end else begin
            rd_byte = slice_lvl;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // control writes; only defined bits are stored, the rest read zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            slicer_control_one        <= vslc_pkg::RST_ZERO;
            programmable_sync_pattern <= vslc_pkg::RST_SYNC_PATTERN;
            horiz_window_low          <= vslc_pkg::RST_ZERO;
            vert_window_low           <= vslc_pkg::RST_ZERO;
            field_and_offset_msbs     <= vslc_pkg::RST_ZERO;
            for (int i = 0; i < vslc_pkg::NUM_LINE_CTRL; i++) begin
                line_type_select[i] <= vslc_pkg::RST_LINE_CTRL;
            end
        end else if (wr_en) begin
            if (idx == vslc_pkg::IDX_SLICER_CONTROL_ONE) begin
                slicer_control_one <= pwdata[7:0] & 8'h70;
            end else if (idx <= vslc_pkg::IDX_LINE_CTRL_LAST) begin
                line_type_select[lcr_wsel] <= pwdata[7:0];
            end else if (idx == vslc_pkg::IDX_SYNC_PATTERN) begin
                programmable_sync_pattern <= pwdata[7:0];
            end else if (idx == vslc_pkg::IDX_HORIZ_LOW) begin
                horiz_window_low <= pwdata[7:0];
            end else if (idx == vslc_pkg::IDX_VERT_LOW) begin
                vert_window_low <= pwdata[7:0];
            end else if (idx == vslc_pkg::IDX_FIELD_MSBS) begin
                field_and_offset_msbs <= pwdata[7:0] & 8'hd7;
            end
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    logic        parity_check_disable;
    logic        sync_error_strict;
    logic        level_search_disable;
    logic        field_flag_invert;
    logic        recode_en;
    logic        vert_window_offset_msb;
    logic [10:0] horiz_window_offset;
    logic [8:0]  vert_window_offset;
    logic [9:0]  vert_window_offset_eff;

    assign parity_check_disable   = slicer_control_one[vslc_pkg::BIT_PARITY_DIS];
    assign sync_error_strict      = slicer_control_one[vslc_pkg::BIT_SYNC_STRICT];
    assign level_search_disable   = slicer_control_one[vslc_pkg::BIT_LEVEL_DIS];
    assign field_flag_invert      = field_and_offset_msbs[vslc_pkg::BIT_FIELD_INV];
    assign recode_en              = field_and_offset_msbs[vslc_pkg::BIT_RECODE];
    assign vert_window_offset_msb = field_and_offset_msbs[vslc_pkg::BIT_VERT_MSB];
    // split fields joined, msbs above the low byte
    assign horiz_window_offset = {field_and_offset_msbs[vslc_pkg::HORIZ_MSB_HI:0],
                                  horiz_window_low};
    assign vert_window_offset  = {vert_window_offset_msb, vert_window_low};
    // settings beyond the documented maximum are clamped, not wrapped
    assign vert_window_offset_eff = ({1'b0, vert_window_offset} > vslc_pkg::VERT_OFFSET_MAX) ?
                      vslc_pkg::VERT_OFFSET_MAX : {1'b0, vert_window_offset};

    // ------------------------------------------------------------
    // line and sample position
    // ------------------------------------------------------------
    logic [9:0]  line_cnt;
    logic [9:0]  rel_line;
    logic [10:0] samp_cnt;
    logic        field_flag;
    logic        in_ctrl_lines;
    logic        in_window;
    logic [3:0]  line_kind;
    logic [4:0]  lcr_rsel;

    // line counter restarts each field, sample counter each line
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            line_cnt <= 10'd0;
            samp_cnt <= 11'd0;
        end else begin
            if (field_start) begin
                line_cnt <= 10'd0;
            end else if (line_start) begin
                line_cnt <= line_cnt + 10'd1;
            end
            if (line_start) begin
                samp_cnt <= 11'd0;
            end else if (vid_valid && samp_cnt != 11'h7ff) begin
                samp_cnt <= samp_cnt + 11'd1;
            end
        end
    end

    assign field_flag    = field_in ^ field_flag_invert;
    assign rel_line      = line_cnt - vert_window_offset_eff;
    assign in_ctrl_lines = line_cnt >= vert_window_offset_eff &&
                           rel_line >= 10'(vslc_pkg::FIRST_CTRL_LINE) &&
                           rel_line < 10'(vslc_pkg::FIRST_CTRL_LINE +
                                          vslc_pkg::NUM_LINE_CTRL);
    assign lcr_rsel      = 5'(rel_line - 10'(vslc_pkg::FIRST_CTRL_LINE));
    assign in_window     = vid_valid && samp_cnt >= horiz_window_offset;

    // field one takes the lower nibble; lines outside the table are active video
    always_comb begin
        line_kind = vslc_pkg::KIND_ACTIVE;
        if (in_ctrl_lines) begin
            line_kind = field_flag ? line_type_select[lcr_rsel][3:0]
                                   : line_type_select[lcr_rsel][7:4];
        end
    end

    // ------------------------------------------------------------
    // amplitude search and bit slicing
    // ------------------------------------------------------------
    logic [7:0] lvl_max;
    logic [7:0] lvl_min;
    logic       slice_bit;

    // the level is set from last line's peaks; a frozen search holds it,
    // which keeps a noisy line from dragging the threshold around
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            slice_lvl <= 8'h80;
            lvl_max   <= 8'h00;
            lvl_min   <= 8'hff;
        end else if (!level_search_disable) begin
            if (line_start) begin
                slice_lvl <= 8'((9'(lvl_max) + 9'(lvl_min)) >> 1);
                lvl_max   <= 8'h00;
                lvl_min   <= 8'hff;
            end else if (in_window) begin
                if (vid_sample > lvl_max) lvl_max <= vid_sample;
                if (vid_sample < lvl_min) lvl_min <= vid_sample;
            end
        end
    end

    assign slice_bit = vid_sample > slice_lvl;

    // ------------------------------------------------------------
    // sync code search and byte assembly
    // ------------------------------------------------------------
    vslc_pkg::vslc_state_t state;
    vslc_pkg::vslc_state_t next_state;
    logic [3:0]  cur_kind;
    logic [23:0] sync_sr;
    logic [4:0]  sync_seen;
    logic [23:0] sync_pat;
    logic [23:0] sync_mask;
    logic [4:0]  sync_len;
    logic [4:0]  sync_errs;
    logic        sync_hit;
    logic        kind_checked;
    logic [2:0]  bit_cnt;
    logic [7:0]  byte_sr;
    logic [1:0]  byte_cnt;
    logic [7:0]  full_byte;

    // sync code and length per kind
    always_comb begin
        sync_pat     = 24'(programmable_sync_pattern);
        sync_mask    = vslc_pkg::MASK_PROG;
        sync_len     = vslc_pkg::LEN_PROG;
        kind_checked = 1'b1;
        unique case (cur_kind)
            vslc_pkg::KIND_CAPTION21: begin
                sync_pat     = vslc_pkg::SYNC_CAPTION;
                sync_mask    = vslc_pkg::MASK_CAPTION;
                sync_len     = vslc_pkg::LEN_CAPTION;
                kind_checked = 1'b0;
            end
            vslc_pkg::KIND_WIDESCREEN: begin
                sync_pat     = vslc_pkg::SYNC_WIDESCREEN;
                sync_mask    = vslc_pkg::MASK_WIDE;
                sync_len     = vslc_pkg::LEN_WIDE;
                kind_checked = 1'b0;
            end
            default: begin
                kind_checked = 1'b1;
            end
        endcase
    end

    assign sync_errs = 5'($countones((sync_sr ^ sync_pat) & sync_mask));
    // a single bit error passes unless strict matching is asked for
    assign sync_hit  = sync_seen >= sync_len &&
                       (sync_errs == 5'd0 ||
                        (sync_errs == 5'd1 && !sync_error_strict));
    assign full_byte = {byte_sr[6:0], slice_bit};

    // start each line by kind; raw kinds skip the search entirely
    always_comb begin
        next_state = state;
        unique case (state)
            vslc_pkg::ST_IDLE: next_state = vslc_pkg::ST_IDLE;
            vslc_pkg::ST_SYNC: if (sync_hit) next_state = vslc_pkg::ST_DATA;
            vslc_pkg::ST_DATA: next_state = vslc_pkg::ST_DATA;
            vslc_pkg::ST_RAW:  next_state = vslc_pkg::ST_RAW;
            default:           next_state = vslc_pkg::ST_IDLE;
        endcase
        if (line_start) begin
            unique case (line_kind)
                vslc_pkg::KIND_BLANK_VIDEO,
                vslc_pkg::KIND_ACTIVE:     next_state = vslc_pkg::ST_RAW;
                vslc_pkg::KIND_CAPTION21,
                vslc_pkg::KIND_WIDESCREEN,
                vslc_pkg::KIND_TC625,
                vslc_pkg::KIND_TC525,
                vslc_pkg::KIND_JAPAN_FSW:  next_state = vslc_pkg::ST_SYNC;
                default:                   next_state = vslc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state    <= vslc_pkg::ST_IDLE;
            cur_kind <= vslc_pkg::KIND_ACTIVE;
        end else begin
            state <= next_state;
            if (line_start) cur_kind <= line_kind;
        end
    end

    // sync shifter and byte assembler
    always_ff @(posedge clk_sys) begin
        if (!nrst || line_start) begin
            sync_sr   <= 24'h00_0000;
            sync_seen <= 5'd0;
            bit_cnt   <= 3'd0;
            byte_sr   <= 8'h00;
            byte_cnt  <= 2'd0;
        end else if (in_window) begin
            if (state == vslc_pkg::ST_SYNC && !sync_hit) begin
                sync_sr <= {sync_sr[22:0], slice_bit};
                if (sync_seen != vslc_pkg::LEN_WIDE) sync_seen <= sync_seen + 5'd1;
            end else if (state == vslc_pkg::ST_DATA) begin
                byte_sr <= full_byte;
                bit_cnt <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7 && byte_cnt != vslc_pkg::CHECKED_BYTES) begin
                    byte_cnt <= byte_cnt + 2'd1;
                end
            end
        end
    end

    // odd-parity hamming 8/4 test; all four checks must pass
    function automatic logic parity_ok(input logic [7:0] b);
        logic a;
        logic c;
        logic d;
        a = b[0] ^ b[1] ^ b[5] ^ b[7];
        c = b[1] ^ b[2] ^ b[3] ^ b[7];
        d = b[1] ^ b[3] ^ b[4] ^ b[5];
        parity_ok = a & c & d & (^b);
    endfunction

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic       emit;
    logic [7:0] emit_byte;
    logic [7:0] recoded;

    assign emit = in_window && (state == vslc_pkg::ST_RAW ||
                  (state == vslc_pkg::ST_DATA && bit_cnt == 3'd7));
    assign emit_byte = (state == vslc_pkg::ST_RAW) ? vid_sample : full_byte;

    // recode keeps the output clear of the reserved sync byte values
    always_comb begin
        recoded = emit_byte;
        if (recode_en && emit_byte == vslc_pkg::BYTE_ALL_LOW) begin
            recoded = vslc_pkg::BYTE_LOW_SUB;
        end else if (recode_en && emit_byte == vslc_pkg::BYTE_ALL_HIGH) begin
            recoded = vslc_pkg::BYTE_HIGH_SUB;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_data       <= 8'h00;
            out_valid      <= 1'b0;
            out_kind       <= vslc_pkg::KIND_ACTIVE;
            out_field      <= 1'b0;
            out_parity_err <= 1'b0;
        end else begin
            out_valid <= emit;
            if (emit) begin
                out_data       <= recoded;
                out_kind       <= cur_kind;
                out_field      <= field_flag;
                out_parity_err <= state == vslc_pkg::ST_DATA && !parity_check_disable &&
                                  kind_checked && byte_cnt != vslc_pkg::CHECKED_BYTES &&
                                  !parity_ok(full_byte);
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // the error flag stands between bytes, so only a fresh byte is judged
    property p_parity_gate;
        out_valid && out_parity_err |-> $past(!parity_check_disable) && $past(kind_checked);
    endproperty
    a_parity_gate: assert property (p_parity_gate) else $error("parity flag while disabled");

    property p_strict_sync;
        (state == vslc_pkg::ST_SYNC && sync_error_strict && !line_start)
            ##1 (state == vslc_pkg::ST_DATA) |-> $past(sync_errs) == 5'd0;
    endproperty
    a_strict_sync: assert property (p_strict_sync) else $error("strict sync took an error");

    property p_level_frozen;
        level_search_disable && $past(level_search_disable) |-> $stable(slice_lvl);
    endproperty
    a_level_frozen: assert property (p_level_frozen) else $error("level moved while frozen");

    property p_raw_kind;
        line_start && (line_kind == vslc_pkg::KIND_BLANK_VIDEO ||
                       line_kind == vslc_pkg::KIND_ACTIVE) |=> state == vslc_pkg::ST_RAW;
    endproperty
    a_raw_kind: assert property (p_raw_kind) else $error("raw kind not passed");

    property p_sync_reset;
        $rose(nrst) |-> programmable_sync_pattern == vslc_pkg::RST_SYNC_PATTERN &&
                        line_type_select[0] == vslc_pkg::RST_LINE_CTRL;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("bad reset value");

    property p_vert_window_offset_limit;
        vert_window_offset_eff <= vslc_pkg::VERT_OFFSET_MAX;
    endproperty
    a_vert_window_offset_limit: assert property (p_vert_window_offset_limit) else $error("vertical offset over limit");

    property p_field_flag;
        out_valid |-> out_field == $past(field_in ^ field_flag_invert);
    endproperty
    a_field_flag: assert property (p_field_flag) else $error("field flag wrong");

    property p_recode;
        out_valid && $past(recode_en) |->
            out_data != vslc_pkg::BYTE_ALL_LOW && out_data != vslc_pkg::BYTE_ALL_HIGH;
    endproperty
    a_recode: assert property (p_recode) else $error("recode let a sync byte through");

    property p_window_start;
        out_valid |-> $past(samp_cnt) >= $past(horiz_window_offset);
    endproperty
    a_window_start: assert property (p_window_start) else $error("output before window");

    c_sync_found:  cover property (state == vslc_pkg::ST_SYNC ##1 state == vslc_pkg::ST_DATA);
    c_parity_err:  cover property (out_valid && out_parity_err);
    c_recoded:     cover property (out_valid && out_data == vslc_pkg::BYTE_HIGH_SUB);
    c_caption:     cover property (out_valid && out_kind == vslc_pkg::KIND_CAPTION21);
endmodule
`default_nettype wire

/* File: tb/vslc_slicer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module vslc_slicer_test;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  vid_sample = 8'h00;
    logic        vid_valid = 1'b0;
    logic        line_start = 1'b0;
    logic        field_start = 1'b0;
    logic        field_in = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  out_data;
    logic        out_valid;
    logic [3:0]  out_kind;
    logic        out_field;
    logic        out_parity_err;
    logic [31:0] rd;
    logic        err;
    logic        got;
    logic [7:0]  lfsr = 8'h55;
    logic [7:0]  shadow [23];
    logic [7:0]  smp [3];
    int          num_errors = 0;
    int          samples_checked = 0;

    always #5 clk_sys = ~clk_sys;

    vslc_slicer dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vid_sample(vid_sample), .vid_valid(vid_valid),
        .line_start(line_start), .field_start(field_start), .field_in(field_in),
        .out_data(out_data), .out_valid(out_valid), .out_kind(out_kind),
        .out_field(out_field), .out_parity_err(out_parity_err));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // byte substitution keeps the two reserved codes off the output
    function automatic logic [7:0] recoded(input logic [7:0] s);
        return (s == 8'h00) ? 8'h03 : ((s == 8'hff) ? 8'hfc : s);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // ends as soon as pready is high; the dut ties it high, so this never waits
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // one valid sample and a quiet cycle; got holds out_valid for it
    task automatic put_sample(input logic [7:0] s);
        vid_sample <= s;
        vid_valid <= 1'b1;
        @(posedge clk_sys);
        vid_valid <= 1'b0;
        @(negedge clk_sys);
        got = out_valid;
        @(posedge clk_sys);
    endtask
    // bits msb first at full swing, so any threshold below 8'hff slices them
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            put_sample(b[k] ? 8'hff : 8'h00);
        end
    endtask
    // one line start pulse followed by a quiet cycle
    task automatic pulse_line();
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, vslc_pkg::IDX_SYNC_PATTERN, 32'h0);
        check(rd, 32'h40);
        for (int i = 0; i < 23; i++) begin
            apb(1'b0, vslc_pkg::IDX_LINE_CTRL_FIRST + 8'(i), 32'h0);
            check(rd, 32'hff);
            lfsr = next_rand(lfsr);
            shadow[i] = lfsr;
            apb(1'b1, vslc_pkg::IDX_LINE_CTRL_FIRST + 8'(i), {4{lfsr}});
        end
        for (int i = 0; i < 23; i++) begin
            apb(1'b0, vslc_pkg::IDX_LINE_CTRL_FIRST + 8'(i), 32'h0);
            check(rd, {24'h0, shadow[i]});
        end
        // shared register: only the documented fields survive
        apb(1'b1, vslc_pkg::IDX_FIELD_MSBS, 32'hff);
        apb(1'b0, vslc_pkg::IDX_FIELD_MSBS, 32'h0);
        check(rd, 32'hd7);
        apb(1'b1, 8'h20, 32'h5a);
        check(32'(err), 32'h1);
        apb(1'b1, vslc_pkg::IDX_FIELD_MSBS, 32'hc0);
        apb(1'b1, vslc_pkg::IDX_VERT_LOW, 32'h03);
        apb(1'b0, vslc_pkg::IDX_VERT_LOW, 32'h0);
        check(rd, 32'h03);
        // first three table entries: a caption line, then two timecode lines
        apb(1'b1, vslc_pkg::IDX_LINE_CTRL_FIRST, 32'h55);
        apb(1'b1, vslc_pkg::IDX_LINE_CTRL_FIRST + 8'd1, 32'h99);
        apb(1'b1, vslc_pkg::IDX_LINE_CTRL_FIRST + 8'd2, 32'h99);
        // line zero falls outside the table, so it carries active video
        field_start <= 1'b1;
        @(posedge clk_sys);
        field_start <= 1'b0;
        pulse_line();
        smp = '{8'h00, 8'hff, next_rand(lfsr)};
        for (int i = 0; i < 3; i++) begin
            put_sample(smp[i]);
            check(32'(got), 32'h1);
            check(32'(out_data), 32'(recoded(smp[i])));
            check(32'(out_kind), 32'hf);
            check(32'(out_field), 32'h1);
            check(32'(out_parity_err), 32'h0);
        end
        // lines 1..4 lie above the table; line 5 is its first entry
        repeat (5) pulse_line();
        put_bits(8'h01, 3);
        lfsr = next_rand(lfsr);
        put_bits(lfsr, 8);
        check(32'(got), 32'h1);
        check(32'(out_kind), 32'h5);
        check(32'(out_data), 32'(recoded(lfsr)));
        check(32'(out_parity_err), 32'h0);
        // one framing error passes while strict matching is off
        pulse_line();
        put_bits(8'h41, 8);
        put_bits(8'h00, 8);
        check(32'(got), 32'h1);
        check(32'(out_kind), 32'h9);
        check(32'(out_parity_err), 32'h1);
        check(32'(out_data), 32'h03);
        put_bits(8'h15, 8);
        check(32'(out_parity_err), 32'h0);
        check(32'(out_data), 32'h15);
        // strict matching skips the faulty code and finds the clean one
        apb(1'b1, vslc_pkg::IDX_SLICER_CONTROL_ONE, 32'h20);
        pulse_line();
        put_bits(8'h41, 8);
        put_bits(8'h40, 8);
        check(32'(got), 32'h0);
        put_bits(8'h15, 8);
        check(32'(got), 32'h1);
        // a frozen search keeps the level although the peaks move
        apb(1'b0, vslc_pkg::IDX_SLICER_STATUS, 32'h0);
        check(rd, 32'h7f);
        apb(1'b1, vslc_pkg::IDX_SLICER_CONTROL_ONE, 32'h10);
        pulse_line();
        put_sample(8'h10);
        put_sample(8'h20);
        pulse_line();
        apb(1'b0, vslc_pkg::IDX_SLICER_STATUS, 32'h0);
        check(rd, 32'h7f);
        tally_and_finish();
    end
endmodule
`default_nettype wire
